// ==== rtl/tap_defs.vh ====
// Constants for the test access port instruction logic.
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH
`define IR_W          3
`define IR_CAPTURE    3'h1
`define OP_EXTEST     3'h0
`define OP_IDCODE     3'h1
`define OP_SAMPLE_Z   3'h2
`define OP_RSV_A      3'h3
`define OP_SAMPLE     3'h4
`define OP_PRIVATE    3'h5
`define OP_RSV_B      3'h6
`define OP_BYPASS     3'h7
`define ID_W          32
`define ST_TLR        4'h0
`define ST_RTI        4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SH_DR      4'h4
`define ST_EX1_DR     4'h5
`define ST_PAU_DR     4'h6
`define ST_EX2_DR     4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SH_IR      4'hB
`define ST_EX1_IR     4'hC
`define ST_PAU_IR     4'hD
`define ST_EX2_IR     4'hE
`define ST_UPD_IR     4'hF
`endif

// ==== rtl/sync2.v ====
// Two-flip-flop synchroniser for a bundle of level inputs.
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ==== rtl/skid_buf.v ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module skid_buf #(
  parameter W = 8
) (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge sys_clk) begin
    if (rst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// ==== rtl/tap_instruction_control.v ====
// Test access port: state machine, instruction register and data register selection.
`timescale 1ns/1ps
`include "tap_defs.vh"
module tap_instruction_control #(
  parameter             BSR_W   = 8,
  parameter [BSR_W-1:0] BSR_PIN = 8'h3F,
  parameter [BSR_W-1:0] BSR_DEF = 8'hFF,
  parameter [BSR_W-1:0] BSR_OUT = 8'h0F,
  parameter [31:0]      ID_CODE = 32'h1234_5679
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             tck,
  input  wire             tms,
  input  wire             tdi,
  output reg              tdo,
  output reg              tdo_oe_n,
  input  wire [BSR_W-1:0] pin_in,
  input  wire [BSR_W-1:0] core_out,
  input  wire [BSR_W-1:0] core_oe_n,
  output reg  [BSR_W-1:0] pad_out,
  output reg  [BSR_W-1:0] pad_oe_n,
  output reg  [BSR_W-1:0] core_in,
  output reg  [`IR_W-1:0] active_ir,
  output reg              drv_valid,
  input  wire             drv_ready,
  output reg  [BSR_W-1:0] drv_data
);
  // ID_CODE default value is arbitrary.

  // ------------------------------------------------------------
  // Input synchronisation and edge detection
  // ------------------------------------------------------------
  wire [2:0] s_q;
  reg        tck_d_r;
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  wire       rise;
  wire       fall;

  sync2 #(.W(3)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({tck, tms, tdi}),
    .q       (s_q)
  );

  assign tck_s = s_q[2];
  assign tms_s = s_q[1];
  assign tdi_s = s_q[0];
  assign rise  = tck_s & ~tck_d_r;
  assign fall  = ~tck_s & tck_d_r;

  // ------------------------------------------------------------
  // Controller state machine
  // ------------------------------------------------------------
  reg [3:0] st_r;
  reg [3:0] st_nxt;

  always @* begin
    st_nxt = st_r;
    case (st_r)
      `ST_TLR:    st_nxt = tms_s ? `ST_TLR    : `ST_RTI;
      `ST_RTI:    st_nxt = tms_s ? `ST_SEL_DR : `ST_RTI;
      `ST_SEL_DR: st_nxt = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: st_nxt = tms_s ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR:  st_nxt = tms_s ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR: st_nxt = tms_s ? `ST_UPD_DR : `ST_PAU_DR;
      `ST_PAU_DR: st_nxt = tms_s ? `ST_EX2_DR : `ST_PAU_DR;
      `ST_EX2_DR: st_nxt = tms_s ? `ST_UPD_DR : `ST_SH_DR;
      `ST_UPD_DR: st_nxt = tms_s ? `ST_SEL_DR : `ST_RTI;
      `ST_SEL_IR: st_nxt = tms_s ? `ST_TLR    : `ST_CAP_IR;
      `ST_CAP_IR: st_nxt = tms_s ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR:  st_nxt = tms_s ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR: st_nxt = tms_s ? `ST_UPD_IR : `ST_PAU_IR;
      `ST_PAU_IR: st_nxt = tms_s ? `ST_EX2_IR : `ST_PAU_IR;
      `ST_EX2_IR: st_nxt = tms_s ? `ST_UPD_IR : `ST_SH_IR;
      `ST_UPD_IR: st_nxt = tms_s ? `ST_SEL_DR : `ST_RTI;
      default:    st_nxt = `ST_TLR;
    endcase
  end

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  wire op_ext;
  wire op_idc;
  wire op_flt;
  wire op_smp;
  wire op_bsr;

  // Codes are compared as 3-bit binary words, shifted in LSB first.
  assign op_ext = (active_ir == `OP_EXTEST);
  assign op_idc = (active_ir == `OP_IDCODE);
  assign op_flt = (active_ir == `OP_SAMPLE_Z);
  assign op_smp = (active_ir == `OP_SAMPLE);
  assign op_bsr = op_ext | op_flt | op_smp;
  // Every other code, reserved and private included, falls to bypass.

  // ------------------------------------------------------------
  // Shift registers, sampled on the rising test clock
  // ------------------------------------------------------------
  reg [`IR_W-1:0] ir_sh_r;
  reg             byp_r;
  reg [`ID_W-1:0] id_r;
  reg [BSR_W-1:0] bsr_r;
  reg [BSR_W-1:0] bsr_upd_r;
  reg             tdo_nxt;
  wire [BSR_W-1:0] pin_cap;

  // Cells without a pin take their default; pin cells take the pad.
  assign pin_cap = (pin_in & BSR_PIN) | (BSR_DEF & ~BSR_PIN);

  always @(posedge sys_clk) begin
    if (rst) begin
      // Matches the synchroniser's reset level so no false rising edge follows reset; a low tck still gives one false fall.
      tck_d_r   <= 1'b1;
      st_r      <= `ST_TLR;
      ir_sh_r   <= `OP_IDCODE;
      active_ir <= `OP_IDCODE;
      byp_r     <= 1'b0;
      id_r      <= {`ID_W{1'b0}};
      bsr_r     <= {BSR_W{1'b0}};
      bsr_upd_r <= {BSR_W{1'b0}};
    end else begin
      tck_d_r <= tck_s;
      if (rise) begin
        st_r <= st_nxt;
        case (st_r)
          `ST_TLR: begin
            active_ir <= `OP_IDCODE;
          end
          `ST_CAP_IR: begin
            ir_sh_r <= `IR_CAPTURE;
          end
          `ST_SH_IR: begin
            ir_sh_r <= {tdi_s, ir_sh_r[`IR_W-1:1]};
          end
          `ST_CAP_DR: begin
            byp_r <= 1'b0;
            if (op_idc) begin
              id_r <= ID_CODE;
            end else if (op_bsr) begin
              bsr_r <= pin_cap;
            end
          end
          `ST_SH_DR: begin
            if (op_idc) begin
              id_r <= {tdi_s, id_r[`ID_W-1:1]};
            end else if (op_bsr) begin
              bsr_r <= {tdi_s, bsr_r[BSR_W-1:1]};
            end else begin
              byp_r <= tdi_s;
            end
          end
          `ST_UPD_DR: begin
            bsr_upd_r <= bsr_r;
          end
          default: begin
          end
        endcase
      end
      // The new instruction takes hold only at Update-IR, on the falling edge.
      if (fall && st_r == `ST_UPD_IR) begin
        active_ir <= ir_sh_r;
      end
    end
  end

  // ------------------------------------------------------------
  // TDO on the falling test clock
  // ------------------------------------------------------------
  always @* begin
    tdo_nxt = byp_r;
    if (st_r == `ST_SH_IR) begin
      tdo_nxt = ir_sh_r[0];
    end else if (op_idc) begin
      tdo_nxt = id_r[0];
    end else if (op_bsr) begin
      tdo_nxt = bsr_r[0];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (fall) begin
      tdo      <= tdo_nxt;
      tdo_oe_n <= ~(st_r == `ST_SH_IR || st_r == `ST_SH_DR);
    end
  end

  // ------------------------------------------------------------
  // Pad control
  // ------------------------------------------------------------
  // Only pad muxes change with the instruction; core_in follows pin_in in every mode.
  always @(posedge sys_clk) begin
    if (rst) begin
      pad_out  <= {BSR_W{1'b0}};
      pad_oe_n <= {BSR_W{1'b1}};
      core_in  <= {BSR_W{1'b0}};
    end else begin
      core_in <= pin_in;
      if (op_flt) begin
        pad_out  <= core_out;
        pad_oe_n <= {BSR_W{1'b1}};
      end else if (op_ext) begin
        pad_out  <= bsr_upd_r;
        pad_oe_n <= ~BSR_OUT;
      end else begin
        pad_out  <= core_out;
        pad_oe_n <= core_oe_n;
      end
    end
  end

  // ------------------------------------------------------------
  // Update-DR words toward the pad driver, through the buffer
  // ------------------------------------------------------------
  wire             b_in_ready;
  wire             b_out_valid;
  wire [BSR_W-1:0] b_out_data;
  reg              push_r;
  wire             b_pop;

  always @(posedge sys_clk) begin
    if (rst) begin
      push_r <= 1'b0;
    end else begin
      push_r <= rise & (st_r == `ST_UPD_DR) & op_bsr;
    end
  end

  assign b_pop = b_out_valid & (~drv_valid | drv_ready);

  skid_buf #(.W(BSR_W)) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push_r),
    .in_ready  (b_in_ready),
    .in_data   (bsr_upd_r),
    .out_valid (b_out_valid),
    .out_ready (~drv_valid | drv_ready),
    .out_data  (b_out_data)
  );

  always @(posedge sys_clk) begin
    if (rst) begin
      drv_valid <= 1'b0;
      drv_data  <= {BSR_W{1'b0}};
    end else if (b_pop) begin
      drv_valid <= 1'b1;
      drv_data  <= b_out_data;
    end else if (drv_ready) begin
      drv_valid <= 1'b0;
    end
  end
endmodule

// ==== test/tap_chk.sv ====
// Assertions on the ports of the test port instruction logic.
`timescale 1ns/1ps
`include "tap_defs.vh"
module tap_chk #(
  parameter             BSR_W   = 8,
  parameter [BSR_W-1:0] BSR_OUT = 8'h0F
) (
  input wire             sys_clk,
  input wire             rst,
  input wire             tck,
  input wire             tdo,
  input wire             tdo_oe_n,
  input wire [BSR_W-1:0] pin_in,
  input wire [BSR_W-1:0] core_out,
  input wire [BSR_W-1:0] core_oe_n,
  input wire [BSR_W-1:0] pad_out,
  input wire [BSR_W-1:0] pad_oe_n,
  input wire [BSR_W-1:0] core_in,
  input wire [2:0]       active_ir,
  input wire             drv_valid,
  input wire             drv_ready,
  input wire [BSR_W-1:0] drv_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence normal_s;
    (active_ir != `OP_EXTEST && active_ir != `OP_SAMPLE_Z && $stable(core_out)
      && $stable(core_oe_n))[*3];
  endsequence
  sequence stall_s;
    drv_valid && !drv_ready;
  endsequence
  reset_ir_a: assert property ($fell(rst) |-> active_ir == `OP_IDCODE && tdo_oe_n)
    else $error("state after reset wrong");
  tdo_edge_a: assert property ($changed(tdo) |-> !tck && !$past(tck))
    else $error("serial output moved outside a low test clock");
  oe_edge_a: assert property ($changed(tdo_oe_n) |-> !tck && !$past(tck))
    else $error("serial enable moved outside a low test clock");
  ir_update_a: assert property ($changed(active_ir) && active_ir != `OP_IDCODE
    |-> !tck && !$past(tck))
    else $error("instruction changed outside a falling test clock");
  float_pads_a: assert property ((active_ir == `OP_SAMPLE_Z)[*3] |-> &pad_oe_n)
    else $error("outputs not floated");
  extest_drive_a: assert property ((active_ir == `OP_EXTEST)[*3]
    |-> (pad_oe_n & BSR_OUT) == '0)
    else $error("output cells not driving");
  normal_pads_a: assert property (normal_s |-> pad_out == core_out && pad_oe_n == core_oe_n)
    else $error("pads not following core");
  core_pass_a: assert property ($stable(pin_in)[*3] |-> core_in == pin_in)
    else $error("core inputs overridden");
  drv_hold_a: assert property (stall_s |=> drv_valid && $stable(drv_data))
    else $error("word dropped while stalled");
endmodule

// ==== test/scan_ctl.sv ====
// Scan chain controller model that drives the test port pins.
`timescale 1ns/1ps
module scan_ctl (
  input  wire sys_clk,
  input  wire tdo,
  output reg  tck,
  output reg  tms,
  output reg  tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One 90 ns test clock period; the clock rests low and the pulled-up data line high between uses.
  task tk(input logic m, input logic d, output logic o);
    @(negedge sys_clk);
    tms = m;
    tdi = d;
    repeat (4) @(negedge sys_clk);
    o = tdo;
    tck = 1'b1;
    repeat (4) @(negedge sys_clk);
    tck = 1'b0;
  endtask
  task go_reset;
    logic o;
    for (int i = 0; i < 5; i++) tk(1'b1, 1'b1, o);
    tk(1'b0, 1'b1, o);
  endtask
  // Walks from idle to a shift state and stops in the first exit state.
  task shift(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    logic o;
    q = '0;
    tk(1'b1, 1'b1, o);
    if (ir) tk(1'b1, 1'b1, o);
    tk(1'b0, 1'b1, o);
    tk(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, d[i], o);
      q[i] = o;
    end
  endtask
  task finish;
    logic o;
    tk(1'b1, 1'b1, o);
    tk(1'b0, 1'b1, o);
  endtask
endmodule

// ==== test/tap_instruction_control_tb.sv ====
// Testbench for the test port instruction logic with a scan controller model.
`timescale 1ns/1ps
`include "tap_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, g, e); end end
module tap_instruction_control_tb;
  localparam logic [31:0] ID   = 32'h0C3A_5E11; // Arbitrary value.
  localparam logic [7:0]  PIN  = 8'h3F;
  localparam logic [7:0]  DEF  = 8'hFF;
  localparam logic [7:0]  OUTM = 8'h0F;
  localparam logic [2:0]  BYP [4] = '{`OP_RSV_A, `OP_PRIVATE, `OP_RSV_B, `OP_BYPASS};
  localparam logic [7:0]  WRD [3] = '{8'h11, 8'h22, 8'h33};
  logic        sys_clk, rst, tck, tms, tdi, tdo, tdo_oe_n, drv_valid, drv_ready;
  logic [7:0]  pin_in, core_out, core_oe_n, pad_out, pad_oe_n, core_in, drv_data;
  logic [2:0]  active_ir;
  logic [31:0] q;
  int          fail_count, n_compared, cyc, k;
  tap_instruction_control #(.BSR_PIN(PIN), .BSR_DEF(DEF), .BSR_OUT(OUTM), .ID_CODE(ID)) u_dut (
    .sys_clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .pin_in, .core_out, .core_oe_n,
    .pad_out, .pad_oe_n, .core_in, .active_ir, .drv_valid, .drv_ready, .drv_data);
  scan_ctl u_ctl (.sys_clk, .tdo, .tck, .tms, .tdi);
  function automatic logic [7:0] cap(input logic [7:0] p);
    return (p & PIN) | (~PIN & DEF);
  endfunction
  task load(input logic [2:0] c);
    u_ctl.shift(1'b1, 3, {29'h0, c}, q);
    u_ctl.finish;
  endtask
  task t_id;
    `CHK(active_ir, `OP_IDCODE)
    `CHK(tdo_oe_n, 1'b1)
    u_ctl.shift(1'b0, 32, 32'h0, q);
    `CHK(tdo_oe_n, 1'b0)
    u_ctl.finish;
    `CHK(q, ID)
    `CHK(tdo_oe_n, 1'b1)
  endtask
  task t_ir;
    u_ctl.shift(1'b1, 3, {29'h0, `OP_BYPASS}, q);
    `CHK(q[2:0], `IR_CAPTURE)
    `CHK(active_ir, `OP_IDCODE)
    u_ctl.finish;
    `CHK(active_ir, `OP_BYPASS)
  endtask
  task t_bypass;
    foreach (BYP[i]) begin
      load(BYP[i]);
      `CHK(active_ir, BYP[i])
      u_ctl.shift(1'b0, 4, 32'hB, q);
      u_ctl.finish;
      `CHK(q[3:0], 4'h6)
    end
  endtask
  task t_sample;
    load(`OP_SAMPLE);
    u_ctl.shift(1'b0, 8, 32'h5A, q);
    u_ctl.finish;
    `CHK(q[7:0], cap(8'hA5))
    `CHK(pad_out, core_out)
    `CHK(pad_oe_n, core_oe_n)
  endtask
  task t_extest;
    load(`OP_EXTEST);
    `CHK(pad_out & OUTM, 8'h5A & OUTM)
    `CHK(pad_oe_n & OUTM, 8'h00)
    pin_in = 8'h3C;
    u_ctl.shift(1'b0, 8, 32'h5A, q);
    u_ctl.finish;
    `CHK(q[7:0], cap(8'h3C))
    `CHK(core_in, 8'h3C)
  endtask
  task t_samplez;
    load(`OP_SAMPLE_Z);
    `CHK(pad_oe_n, 8'hFF)
    u_ctl.shift(1'b0, 8, 32'h0, q);
    u_ctl.finish;
    `CHK(q[7:0], cap(8'h3C))
  endtask
  task t_buffer;
    load(`OP_SAMPLE);
    drv_ready = 1'b0;
    foreach (WRD[i]) begin
      u_ctl.shift(1'b0, 8, {24'h0, WRD[i]}, q);
      u_ctl.finish;
    end
    `CHK(drv_valid, 1'b1)
    `CHK(drv_data, WRD[0])
    k = 1;
    drv_ready = 1'b1;
    repeat (20) begin
      @(negedge sys_clk);
      if (drv_valid === 1'b1 && k < 3) begin
        `CHK(drv_data, WRD[k])
        k++;
      end
    end
    `CHK(k, 3)
  endtask
  task t_tlr;
    load(`OP_BYPASS);
    u_ctl.go_reset;
    `CHK(active_ir, `OP_IDCODE)
  endtask
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim;
    end
  end
  initial begin
    rst = 1'b1;
    drv_ready = 1'b1;
    pin_in = 8'hA5;
    core_out = 8'h96;
    core_oe_n = 8'h0F;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    u_ctl.go_reset;
    t_id;
    t_ir;
    t_bypass;
    t_sample;
    t_extest;
    t_samplez;
    t_buffer;
    t_tlr;
    end_sim;
  end
endmodule
bind tap_instruction_control tap_chk #(.BSR_W(BSR_W), .BSR_OUT(BSR_OUT)) u_chk (
  .sys_clk, .rst, .tck, .tdo, .tdo_oe_n, .pin_in, .core_out, .core_oe_n, .pad_out,
  .pad_oe_n, .core_in, .active_ir, .drv_valid, .drv_ready, .drv_data);
